// ### verilog/acp_convert_start_port.sv
// converter control and serial output port, top level
// Functional notes
// RL1 - convert_start rise holds input, starts conversion
// RL2 - serial clock rise advances sequence, shifts bit
// RL3 - conversion lasts seventeen to eighteen clocks
// RL4 - output word is previous conversion's sample
// RL5 - late convert_start delays output one clock
// RL6 - host raises convert_start half clock early
// RL7 - acquire from sixteenth edge to next start
// RL8 - host keeps clock period within limits
// RL9 - output bit held until clock advances
// RL10 - host captures each bit on rising edge
// RL11 - two starts, clock still: nap mode
// RL12 - four or more starts: sleep mode
// RL13 - serial clock pulses wake from sleep
// RL14 - host waits reference settling after wake
// RL15 - fourteen or twelve bit results by variant
// RL16 - over range all ones, under all zeros
// RL17 - output high impedance after last bit
`timescale 1ns/1ns
`default_nettype none

module acp_convert_start_port #(
  parameter bit WIDE_VARIANT   = 1'b1,
  parameter int SETTLE_CYCLES  = acp_pkg::REF_SETTLE_CYC
) (
  input  wire logic                ref_clk,
  input  wire logic                rst,
  input  wire logic                sck,
  input  wire logic                convertStart,
  input  wire acp_pkg::acp_sample_t analogSample,
  output var  logic                serialData,
  output var  logic                serialDataOe,
  output var  acp_pkg::acp_phase_t phase,
  output var  acp_pkg::acp_power_t powerMode,
  output var  logic                refReady
);

  // ---------------------------------------------------------------
  // serial clock domain signals
  // ---------------------------------------------------------------
  logic                rstSck;
  logic                convSync;
  logic                convPrev;
  logic                sleepSync;
  logic                startPulse;
  logic                frameDone;
  logic                sckToggle;
  logic [4:0]          busyCnt;
  logic [15:0]         resultWord;
  logic [15:0]         newWord;
  logic                next_convPrev;
  logic                next_sckToggle;
  logic [4:0]          next_busyCnt;
  logic [15:0]         next_resultWord;
  acp_pkg::acp_phase_t next_phase;

  // ---------------------------------------------------------------
  // reference clock domain signals
  // ---------------------------------------------------------------
  logic                convRef;
  logic                convRefPrev;
  logic                toggleRef;
  logic                toggleRefPrev;
  logic                sleepFlag;
  logic [2:0]          pulseCnt;
  logic [31:0]         settleCnt;
  logic                next_convRefPrev;
  logic                next_toggleRefPrev;
  logic                next_sleepFlag;
  logic [2:0]          next_pulseCnt;
  logic [31:0]         next_settleCnt;
  logic                next_refReady;
  acp_pkg::acp_power_t next_powerMode;

  // ---------------------------------------------------------------
  // crossings into the serial clock domain
  // ---------------------------------------------------------------
  acp_bit_sync u_rst_sync (
    .clk  (sck),
    .rst  (1'b0),
    .din  (rst),
    .dout (rstSck)
  );

  // start seen late by setup lands one edge later [RL5]
  acp_bit_sync u_convert_start_sync (
    .clk  (sck),
    .rst  (rstSck),
    .din  (convertStart),
    .dout (convSync)
  );

  acp_bit_sync u_sleep_sync (
    .clk  (sck),
    .rst  (rstSck),
    .din  (sleepFlag),
    .dout (sleepSync)
  );

  // ---------------------------------------------------------------
  // start detection and result formatting
  // ---------------------------------------------------------------
  assign startPulse = convSync & ~convPrev & ~sleepSync;  // start on rising edge [RL1]

  // clamp out-of-range input and pick resolution
  always_comb begin
    newWord = acp_pkg::WORD_ZERO;
    if (WIDE_VARIANT) begin
      if (analogSample.over) begin
        newWord = 16'h3fff;                          // all ones [RL16]
      end else if (!analogSample.under) begin
        newWord = {2'b00, analogSample.code};        // fourteen bits [RL15]
      end
    end else begin
      if (analogSample.over) begin
        newWord = 16'h0fff;                          // all ones [RL16]
      end else if (!analogSample.under) begin
        newWord = {4'h0, analogSample.code[13:2]};   // twelve bits [RL15]
      end
    end
  end

  // ---------------------------------------------------------------
  // conversion sequence, one step per rising serial clock
  // ---------------------------------------------------------------
  always_comb begin
    next_convPrev   = convSync;
    next_sckToggle  = ~sckToggle;   // activity marker for wake-up
    next_busyCnt    = busyCnt;
    next_resultWord = resultWord;
    next_phase      = phase;
    if (rstSck) begin
      next_convPrev   = 1'b0;
      next_sckToggle  = 1'b0;
      next_busyCnt    = 5'h00;
      next_resultWord = acp_pkg::WORD_ZERO;
      next_phase      = '0;
    end else if (startPulse) begin
      next_resultWord = newWord;        // read out in next frame [RL4]
      next_busyCnt    = 5'h01;
      next_phase.hold      = 1'b1;      // input held [RL1]
      next_phase.busy      = 1'b1;
      next_phase.acquiring = 1'b0;      // acquisition ends at start [RL7]
    end else begin
      if (phase.busy) begin
        if (busyCnt == acp_pkg::CONVERT_START_CYCLES) begin
          next_phase.busy = 1'b0;       // conversion done [RL3]
        end else begin
          next_busyCnt = busyCnt + 5'h01;   // [RL2]
        end
      end
      if (frameDone) begin
        next_phase.hold      = 1'b0;
        next_phase.acquiring = 1'b1;    // acquire from sixteenth edge [RL7]
      end
    end
  end

  always_ff @(posedge sck) begin
    convPrev   <= next_convPrev;
    sckToggle  <= next_sckToggle;
    busyCnt    <= next_busyCnt;
    resultWord <= next_resultWord;
    phase      <= next_phase;
  end

  // ---------------------------------------------------------------
  // serial output, previous result loaded at each start
  // ---------------------------------------------------------------
  acp_shift_out u_shift (
    .clk       (sck),
    .rst       (rstSck),
    .load      (startPulse),
    .word      (resultWord),        // previous conversion [RL4]
    .sdo       (serialData),
    .sdoOe     (serialDataOe),
    .frameDone (frameDone)
  );

  // ---------------------------------------------------------------
  // crossings into the reference clock domain
  // ---------------------------------------------------------------
  acp_bit_sync u_convert_start_ref (
    .clk  (ref_clk),
    .rst  (rst),
    .din  (convertStart),
    .dout (convRef)
  );

  acp_bit_sync u_toggle_ref (
    .clk  (ref_clk),
    .rst  (rst),
    .din  (sckToggle),
    .dout (toggleRef)
  );

  // ---------------------------------------------------------------
  // power-down detection and wake-up
  // ---------------------------------------------------------------
  always_comb begin
    next_convRefPrev   = convRef;
    next_toggleRefPrev = toggleRef;
    next_pulseCnt      = pulseCnt;
    next_powerMode     = powerMode;
    next_sleepFlag     = sleepFlag;
    next_settleCnt     = settleCnt;
    next_refReady      = refReady;
    if (rst) begin
      next_convRefPrev   = 1'b0;
      next_toggleRefPrev = 1'b0;
      next_pulseCnt      = 3'h0;
      next_powerMode     = acp_pkg::PWR_ACTIVE;
      next_sleepFlag     = 1'b0;
      next_settleCnt     = 32'h0000_0000;
      next_refReady      = 1'b1;
    end else if (toggleRef != toggleRefPrev) begin
      // clock moved: count restarts, device wakes [RL13]
      next_pulseCnt  = 3'h0;
      next_powerMode = acp_pkg::PWR_ACTIVE;
      next_sleepFlag = 1'b0;
      if (powerMode == acp_pkg::PWR_SLEEP) begin
        next_refReady  = 1'b0;
        next_settleCnt = 32'h0000_0000;
      end
    end else if (convRef && !convRefPrev) begin
      if (pulseCnt != acp_pkg::SLEEP_PULSES) begin
        next_pulseCnt = pulseCnt + 3'h1;
      end
      if (pulseCnt + 3'h1 >= acp_pkg::SLEEP_PULSES) begin
        next_powerMode = acp_pkg::PWR_SLEEP;    // [RL12]
        next_sleepFlag = 1'b1;
      end else if (pulseCnt + 3'h1 >= acp_pkg::NAP_PULSES) begin
        next_powerMode = acp_pkg::PWR_NAP;      // [RL11]
      end
    end
    // reference settling after wake, host waits on it
    if (!rst && !refReady && powerMode != acp_pkg::PWR_SLEEP) begin
      if (settleCnt >= 32'(SETTLE_CYCLES - 1)) begin
        next_refReady = 1'b1;
      end else begin
        next_settleCnt = settleCnt + 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    convRefPrev   <= next_convRefPrev;
    toggleRefPrev <= next_toggleRefPrev;
    pulseCnt      <= next_pulseCnt;
    powerMode     <= next_powerMode;
    sleepFlag     <= next_sleepFlag;
    settleCnt     <= next_settleCnt;
    refReady      <= next_refReady;
  end

endmodule : acp_convert_start_port

`default_nettype wire

// ### verilog/acp_pkg.sv
// shared constants and types for the converter serial port
package acp_pkg;

  // ---------------------------------------------------------------
  // resolution and frame layout
  // ---------------------------------------------------------------
  localparam int          WIDE_BITS   = 14;
  localparam int          NARROW_BITS = 12;
  localparam int          CODE_W      = 14;
  localparam int          FRAME_BITS  = 16;
  localparam logic [4:0]  FRAME_LAST  = 5'h10;     // edge that ends the data frame
  localparam logic [4:0]  CONVERT_START_CYCLES = 5'h11;     // serial clocks a conversion occupies
  localparam logic [15:0] WORD_ZERO   = 16'h0000;

  // ---------------------------------------------------------------
  // power-down detection
  // ---------------------------------------------------------------
  localparam logic [2:0] NAP_PULSES   = 3'h2;
  localparam logic [2:0] SLEEP_PULSES = 3'h4;

  // ---------------------------------------------------------------
  // timing, against the 10 MHz reference clock
  // ---------------------------------------------------------------
  localparam int REF_CLK_HZ      = 10_000_000;
  localparam int CONVERT_START_SETUP_NS   = 3;
  localparam int CONVERT_START_SETUP_RAW  = (CONVERT_START_SETUP_NS * (REF_CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int CONVERT_START_SETUP_CYC  = (CONVERT_START_SETUP_RAW < 1) ? 1 : CONVERT_START_SETUP_RAW;
  localparam int REF_SETTLE_US   = 2000;
  localparam int REF_SETTLE_CYC  = REF_SETTLE_US * (REF_CLK_HZ / 1_000_000);

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    PWR_ACTIVE,
    PWR_NAP,
    PWR_SLEEP
  } acp_power_t;

  typedef struct packed {
    logic              over;   // difference above full scale
    logic              under;  // difference below zero
    logic [CODE_W-1:0] code;   // quantised difference, 14 bits
  } acp_sample_t;

  typedef struct packed {
    logic hold;       // input held
    logic busy;       // conversion in progress
    logic acquiring;  // input tracked
  } acp_phase_t;

endpackage : acp_pkg

// ### verilog/acp_bit_sync.sv
// two-flop synchroniser for one level
`timescale 1ns/1ns
`default_nettype none

module acp_bit_sync (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic din,
  output var  logic dout
);

  logic stage1;
  logic next_stage1;
  logic next_dout;

  // ---------------------------------------------------------------
  // next values, first stage feeds only the second
  // ---------------------------------------------------------------
  always_comb begin
    next_stage1 = rst ? 1'b0 : din;
    next_dout   = rst ? 1'b0 : stage1;
  end

  always_ff @(posedge clk) begin
    stage1 <= next_stage1;
    dout   <= next_dout;
  end

endmodule : acp_bit_sync

`default_nettype wire

// ### verilog/acp_shift_out.sv
// serial word shifter with three-state control
`timescale 1ns/1ns
`default_nettype none

module acp_shift_out (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        load,
  input  wire logic [15:0] word,
  output var  logic        sdo,
  output var  logic        sdoOe,
  output var  logic        frameDone
);

  logic [15:0] shiftReg;
  logic [4:0]  bitCnt;
  logic [15:0] next_shiftReg;
  logic [4:0]  next_bitCnt;
  logic        next_sdo;
  logic        next_sdoOe;

  // last bit edge seen in the same cycle, so acquisition starts on it [RL7]
  assign frameDone = sdoOe & ~rst & ~load & (bitCnt == acp_pkg::FRAME_LAST);

  // ---------------------------------------------------------------
  // msb first, one bit per rising edge
  // ---------------------------------------------------------------
  always_comb begin
    next_shiftReg  = shiftReg;
    next_bitCnt    = bitCnt;
    next_sdo       = sdo;          // bit held while clock stands [RL9]
    next_sdoOe     = sdoOe;
    if (rst) begin
      next_shiftReg = acp_pkg::WORD_ZERO;
      next_bitCnt   = 5'h00;
      next_sdo      = 1'b0;
      next_sdoOe    = 1'b0;
    end else if (load) begin
      next_sdo      = word[15];
      next_shiftReg = {word[14:0], 1'b0};
      next_bitCnt   = 5'h01;
      next_sdoOe    = 1'b1;
    end else if (sdoOe) begin
      if (bitCnt == acp_pkg::FRAME_LAST) begin
        next_sdoOe     = 1'b0;    // release line after last bit [RL17]
      end else begin
        next_sdo      = shiftReg[15];  // next bit on rising edge [RL2]
        next_shiftReg = {shiftReg[14:0], 1'b0};
        next_bitCnt   = bitCnt + 5'h01;
      end
    end
  end

  always_ff @(posedge clk) begin
    shiftReg  <= next_shiftReg;
    bitCnt    <= next_bitCnt;
    sdo       <= next_sdo;
    sdoOe     <= next_sdoOe;
  end

endmodule : acp_shift_out

`default_nettype wire

// ### verification/acp_convert_start_port_properties.sv
// concurrent checks on the converter port pins
`timescale 1ns/1ns
`default_nettype none

module acp_convert_start_port_properties #(
  parameter int SETTLE_CYCLES = 8
) (
  input wire logic                ref_clk,
  input wire logic                rst,
  input wire logic                sck,
  input wire logic                convertStart,
  input wire logic                serialDataOe,
  input wire acp_pkg::acp_phase_t phase,
  input wire acp_pkg::acp_power_t powerMode,
  input wire logic                refReady
);
  // ------
  // link side
  // ------
  AST_START_LATENCY: assert property (@(posedge sck) disable iff (rst)
    $rose(convertStart) |-> ##[2:3] $rose(serialDataOe)) else $error("start not taken");
  AST_HOLD_AT_START: assert property (@(posedge sck) disable iff (rst)
    $rose(serialDataOe) |-> phase.hold && phase.busy && !phase.acquiring)
    else $error("bad phase at start");
  AST_FRAME_LEN: assert property (@(posedge sck) disable iff (rst)
    $rose(serialDataOe) |-> serialDataOe[*8] ##1 serialDataOe[*8] ##1 !serialDataOe)
    else $error("frame length wrong");
  AST_BUSY_LEN: assert property (@(posedge sck) disable iff (rst)
    $rose(phase.busy) |-> phase.busy[*8] ##1 phase.busy[*8] ##1 phase.busy ##1 !phase.busy)
    else $error("busy length wrong");
  AST_ACQ_AFTER_FRAME: assert property (@(posedge sck) disable iff (rst)
    $fell(serialDataOe) |-> phase.acquiring && !phase.hold) else $error("no acquire");
  AST_ACQ_HELD: assert property (@(posedge sck) disable iff (rst)
    phase.acquiring |=> phase.acquiring || phase.hold) else $error("acquire dropped");
  AST_OE_IDLE: assert property (@(posedge sck) disable iff (rst)
    !phase.busy |-> !serialDataOe) else $error("driving while idle");
  // ------
  // power side
  // ------
  AST_SLEEP_FROM_NAP: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(powerMode == acp_pkg::PWR_SLEEP) |-> $past(powerMode) == acp_pkg::PWR_NAP)
    else $error("sleep not via nap");
  AST_WAKE: assert property (@(posedge ref_clk) disable iff (rst)
    $fell(refReady) |-> powerMode == acp_pkg::PWR_ACTIVE && $past(powerMode) == acp_pkg::PWR_SLEEP)
    else $error("bad wake");
  AST_SETTLE: assert property (@(posedge ref_clk) disable iff (rst)
    $fell(refReady) |-> !refReady[*7] ##[1:2] refReady) else $error("settle time wrong");
  // main scenarios
  CV_FRAME: cover property (@(posedge sck) $rose(serialDataOe));
  CV_SLEEP: cover property (@(posedge ref_clk) powerMode == acp_pkg::PWR_SLEEP);
  CV_WAKE: cover property (@(posedge ref_clk) $fell(refReady));
endmodule : acp_convert_start_port_properties

`default_nettype wire

// ### verification/acp_host_model.sv
// host side: serial clock, convert strobe and word capture
`timescale 1ns/1ns
`default_nettype none

module acp_host_model (
  output var  logic       sck,
  output var  logic       convertStart,
  input  wire logic [1:0] sdo,
  input  wire logic [1:0] oe
);
  // clock rests low between pulses
  initial begin
    sck = 1'b0;
    convertStart = 1'b0;
  end

  // bare clock pulses, strobe low
  task automatic clocks(input int n, input int half);
    repeat (n) begin
      #(half) sck = 1'b1;
      #(half) sck = 1'b0;
    end
  endtask : clocks

  // one frame of 20 pulses; half of 32 gives 64 ns, within limits
  task automatic frame(input int half, output logic [15:0] ww, output logic [15:0] wn);
    convertStart = 1'b1; // half a period ahead of the rise
    for (int i = 0; i < 20; i++) begin
      #(half);
      if (i >= 3 && i < 19) begin
        ww[18-i] = oe[0] ? sdo[0] : 1'bx; // taken at the rise
        wn[18-i] = oe[1] ? sdo[1] : 1'bx; // any slow rate works
      end
      sck = 1'b1;
      #(half) sck = 1'b0;
      if (i == 3) convertStart = 1'b0;
    end
  endtask : frame

  // strobe pulses with the clock still
  task automatic pulses(input int n);
    repeat (n) begin
      #300 convertStart = 1'b1;
      #300 convertStart = 1'b0;
    end
  endtask : pulses
endmodule : acp_host_model

`default_nettype wire

// ### verification/acp_convert_start_port_tb_top.sv
// self-checking bench for the converter serial port
`timescale 1ns/1ns
`default_nettype none

module acp_convert_start_port_tb_top;
  typedef struct packed {
    acp_pkg::acp_sample_t s;
    logic [15:0]          expW;
    logic [15:0]          expN;
  } acp_row_t;
  localparam int SETTLE = 8;
  localparam int LIMIT  = 5000;
  localparam acp_row_t ROWS [6] = '{
    '{'{1'b0, 1'b0, 14'h1234}, 16'h1234, 16'h048d},
    '{'{1'b0, 1'b0, 14'h3fff}, 16'h3fff, 16'h0fff},
    '{'{1'b0, 1'b0, 14'h0001}, 16'h0001, 16'h0000},
    '{'{1'b1, 1'b0, 14'h0005}, 16'h3fff, 16'h0fff}, // over range
    '{'{1'b0, 1'b1, 14'h2222}, 16'h0000, 16'h0000}, // under range
    '{'{1'b0, 1'b0, 14'h2aaa}, 16'h2aaa, 16'h0aaa}};

  logic                 ref_clk;
  logic                 rst;
  wire logic            sck;
  wire logic            convertStart;
  acp_pkg::acp_sample_t analogSample;
  logic                 dataW;
  logic                 dataN;
  logic                 oeW;
  logic                 oeN;
  acp_pkg::acp_phase_t  phaseW;
  acp_pkg::acp_power_t  powerW;
  logic                 readyW;
  logic [15:0]          gotW;
  logic [15:0]          gotN;
  logic [15:0]          prevW;
  logic [15:0]          prevN;
  int                   fails;
  int                   checks;
  int                   cycles;

  acp_convert_start_port #(.WIDE_VARIANT(1'b1), .SETTLE_CYCLES(SETTLE)) acp_convert_start_port_i (
    .ref_clk(ref_clk), .rst(rst), .sck(sck), .convertStart(convertStart),
    .analogSample(analogSample), .serialData(dataW), .serialDataOe(oeW),
    .phase(phaseW), .powerMode(powerW), .refReady(readyW));
  acp_convert_start_port #(.WIDE_VARIANT(1'b0), .SETTLE_CYCLES(SETTLE)) acp_convert_start_port_n_i (
    .ref_clk(ref_clk), .rst(rst), .sck(sck), .convertStart(convertStart),
    .analogSample(analogSample), .serialData(dataN), .serialDataOe(oeN),
    .phase(), .powerMode(), .refReady());
  acp_host_model acp_host_model_i (
    .sck(sck), .convertStart(convertStart), .sdo({dataN, dataW}), .oe({oeN, oeW}));

  // ------
  // clock, timeout and reporting
  // ------
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      fails++;
      end_of_test();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic end_of_test();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_of_test

  // ------
  // main sequence
  // ------
  initial begin
    rst = 1'b1;
    analogSample = '0;
    fails = 0;
    checks = 0;
    cycles = 0;
    acp_host_model_i.clocks(6, 32);
    repeat (16) @(negedge ref_clk);
    rst = 1'b0;
    acp_host_model_i.clocks(3, 32);
    check(16'({oeW, phaseW, readyW}), 16'h0001);
    check(16'(powerW), 16'(acp_pkg::PWR_ACTIVE));
    $display("reset done");
    prevW = 16'h0000;
    prevN = 16'h0000;
    foreach (ROWS[k]) begin
      @(negedge ref_clk) analogSample = ROWS[k].s;
      acp_host_model_i.frame(32, gotW, gotN);
      check(gotW, prevW);
      check(gotN, prevN);
      check(16'(oeW), 16'h0000);
      prevW = ROWS[k].expW;
      prevN = ROWS[k].expN;
      $display("row %0d done", k);
    end
    // slow read of the last row's word
    acp_host_model_i.frame(200, gotW, gotN);
    check(gotW, prevW);
    $display("slow frame done");
    // nap, sleep and wake
    acp_host_model_i.pulses(2);
    repeat (5) @(negedge ref_clk);
    check(16'(powerW), 16'(acp_pkg::PWR_NAP));
    acp_host_model_i.pulses(1);
    repeat (5) @(negedge ref_clk);
    check(16'(powerW), 16'(acp_pkg::PWR_NAP));
    acp_host_model_i.pulses(1);
    repeat (5) @(negedge ref_clk);
    check(16'(powerW), 16'(acp_pkg::PWR_SLEEP));
    acp_host_model_i.clocks(1, 32);
    repeat (5) @(negedge ref_clk);
    check(16'({powerW, readyW}), 16'h0000);
    for (int i = 0; i < 30 && readyW !== 1'b1; i++) @(negedge ref_clk);
    check(16'(readyW), 16'h0001);
    acp_host_model_i.clocks(4, 32);
    acp_host_model_i.frame(32, gotW, gotN);
    check(gotW, prevW);
    check(gotN, prevN);
    $display("power test done");
    end_of_test();
  end
endmodule : acp_convert_start_port_tb_top

bind acp_convert_start_port acp_convert_start_port_properties #(.SETTLE_CYCLES(SETTLE_CYCLES)) props_i (
  .ref_clk(ref_clk), .rst(rst), .sck(sck), .convertStart(convertStart),
  .serialDataOe(serialDataOe), .phase(phase), .powerMode(powerMode), .refReady(refReady));

`default_nettype wire
